// *** adcsq_pkg.sv ***
// adcsq_pkg: constants shared by the acquisition sequencer, its timer and its sample fifo.
// assumes a single 100 MHz clock domain and byte/word register access by local select code.
package adcsq_pkg;
	localparam int CLK_HZ      = 100_000_000;
	localparam int TMR_SRC_HZ  = 2_000_000;
	localparam int TICK_CYCLES = CLK_HZ / TMR_SRC_HZ;
	localparam int TICK_W      = 6;

	localparam int ADC_W      = 12;
	localparam int SAMPLE_W   = 16;
	localparam int ADDR_W     = 16;
	localparam int LEFT_PAD   = SAMPLE_W - ADC_W;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W     = ADDR_W + SAMPLE_W;
	localparam int RAM_WORDS  = 65536;
	localparam int SCAN_WORDS = 256;

	// register select codes on the local register port
	localparam int SEL_W = 4;
	localparam logic [SEL_W-1:0] SEL_STATUS       = 4'h0;
	localparam logic [SEL_W-1:0] SEL_CONTROL      = 4'h1;
	localparam logic [SEL_W-1:0] SEL_SCAN         = 4'h2;
	localparam logic [SEL_W-1:0] SEL_COUNT        = 4'h3;
	localparam logic [SEL_W-1:0] SEL_PRE_TRIG_PTR = 4'h4;
	localparam logic [SEL_W-1:0] SEL_START        = 4'h5;
	localparam logic [SEL_W-1:0] SEL_CTR_CTL      = 4'h6;
	localparam logic [SEL_W-1:0] SEL_PRESCALE     = 4'h7;
	localparam logic [SEL_W-1:0] SEL_CONV_TMR     = 4'h8;

	// board_status fields
	localparam int ST_RED_OFF  = 0;
	localparam int ST_GREEN    = 1;
	localparam int ST_IRQ_EN   = 3;
	localparam int ST_MEM_HALF = 6;
	localparam int ST_DONE     = 7;
	localparam logic [7:0] STATUS_WMASK = 8'h0b;
	localparam logic [7:0] STATUS_RST   = 8'h00;

	// board_control fields
	localparam int CT_CONT    = 0;
	localparam int CT_MEMIRQ  = 1;
	localparam int CT_EXTTRIG = 2;
	localparam int CT_TIMER   = 3;
	localparam logic [3:0] CONTROL_RST = 4'h0;

	// scan code fields
	localparam int SC_CHAN_LSB = 0;
	localparam int SC_CHAN_W   = 5;
	localparam int SC_GAIN_LSB = 5;
	localparam int SC_GAIN_W   = 2;
	localparam int SC_LAST     = 7;

	localparam logic [14:0] HALF_LAST = 15'h7fff;

	// counter control word: bits 7:6 pick the counter, bits 5:4 the byte access mode
	localparam logic [1:0] TC_SEL_PRESCALE = 2'h1;
	localparam logic [1:0] TC_SEL_CONV     = 2'h2;
	localparam logic [1:0] TC_RW_LSB       = 2'h1;
	localparam logic [1:0] TC_RW_MSB       = 2'h2;
	localparam logic [1:0] TC_RW_BOTH      = 2'h3;
endpackage

// *** adcsq_stream_if.sv ***
// adcsq_stream_if: valid/ready word stream between the sequencer and its sample fifo.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface adcsq_stream_if #(parameter int WIDTH = 32) ();
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport tx (output valid, output data, input ready);
	modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** adcsq_fifo.sv ***
// adcsq_fifo: synchronous first-in first-out buffer with valid/ready on both sides.
// assumes DEPTH of at least two; a word is taken when valid and ready meet on an edge.
`timescale 1ns/1ps
`default_nettype none
module adcsq_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic      clock_i,
	input wire logic      reset_n_i,
	adcsq_stream_if.rx    in_if,
	adcsq_stream_if.tx    out_if
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} adcsq_fifo_state_t;

	adcsq_fifo_state_t q;
	adcsq_fifo_state_t d;
	logic [WIDTH-1:0]  mem [DEPTH];
	logic              push;
	logic              pop;

	assign in_if.ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_if.valid = (q.cnt != '0);
	assign out_if.data  = mem[q.rp];
	assign push         = in_if.valid & in_if.ready;
	assign pop          = out_if.valid & out_if.ready;

	always_comb begin
		d = q;
		if (push) begin
			d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
		end
		if (pop) begin
			d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// storage carries no reset; only the pointers decide what is valid
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[q.wp] <= in_if.data;
		end
	end
endmodule
`default_nettype wire

// *** adcsq_timer.sv ***
// adcsq_timer: cascaded prescaler and conversion timer counters fed by a 2 MHz tick.
// assumes the host loads both counts before enabling; counts below two are not meaningful.
`timescale 1ns/1ps
`default_nettype none
module adcsq_timer
	import adcsq_pkg::*;
(
	input wire logic       clock_i,
	input wire logic       reset_n_i,
	input wire logic       run_i,
	input wire logic       ctl_wr_i,
	input wire logic       psc_wr_i,
	input wire logic       ctm_wr_i,
	input wire logic [7:0] wdata_i,
	output logic           fire_o
);
	typedef struct packed {
		logic [TICK_W-1:0] div;
		logic [1:0]        mode1;
		logic [1:0]        mode2;
		logic              hi1;
		logic              hi2;
		logic [15:0]       r1;
		logic [15:0]       r2;
		logic [15:0]       c1;
		logic [15:0]       c2;
		logic              fire;
	} adcsq_tmr_state_t;

	adcsq_tmr_state_t q;
	adcsq_tmr_state_t d;
	logic             tick;

	// returns {next msb flag, new reload value}
	function automatic logic [16:0] load_byte(input logic [1:0] mode, input logic hi,
			input logic [15:0] cur, input logic [7:0] b);
		logic [16:0] r;
		r = {hi, cur};
		unique case (mode)
			TC_RW_LSB:  r = {1'b0, 8'h00, b};
			TC_RW_MSB:  r = {1'b0, b, 8'h00};
			TC_RW_BOTH: r = hi ? {1'b0, b, cur[7:0]} : {1'b1, cur[15:8], b};
			default:    r = {hi, cur};
		endcase
		return r;
	endfunction

	assign tick   = (q.div == TICK_W'(TICK_CYCLES - 1));
	assign fire_o = q.fire;

	always_comb begin
		logic step2;
		step2  = 1'b0;
		d      = q;
		d.fire = 1'b0;
		d.div  = tick ? '0 : q.div + TICK_W'(1);
		if (ctl_wr_i) begin
			if (wdata_i[7:6] == TC_SEL_PRESCALE) begin
				d.mode1 = wdata_i[5:4];
				d.hi1   = 1'b0;
			end else if (wdata_i[7:6] == TC_SEL_CONV) begin
				d.mode2 = wdata_i[5:4];
				d.hi2   = 1'b0;
			end
		end
		if (psc_wr_i) begin
			{d.hi1, d.r1} = load_byte(q.mode1, q.hi1, q.r1, wdata_i);
		end
		if (ctm_wr_i) begin
			{d.hi2, d.r2} = load_byte(q.mode2, q.hi2, q.r2, wdata_i);
		end
		// period is r1 * r2 ticks of 0.5 us
		if (!run_i) begin
			d.c1 = q.r1;
			d.c2 = q.r2;
		end else if (tick) begin
			if (q.c1 <= 16'h0001) begin
				d.c1  = q.r1;
				step2 = 1'b1;
			end else begin
				d.c1 = q.c1 - 16'h0001;
			end
			if (step2) begin
				if (q.c2 <= 16'h0001) begin
					d.c2   = q.r2;
					d.fire = 1'b1;
				end else begin
					d.c2 = q.c2 - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// *** adcsq_sequencer.sv ***
// adcsq_sequencer: acquisition control of a multichannel converter board with sample RAM.
// assumes the converter runs on clock_i, answering each start with one done pulse;
// the external trigger pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) 12-bit result left-justified in 16-bit word
// (R2) status bits drive red, green, sysfail, irq enable
// (R3) control bit0 picks block or continuous
// (R4) control bit1 picks completion or memory interrupt
// (R5) control bit2 picks external or software trigger
// (R6) control bit3 enables periodic conversion timer
// (R7) scan code: channel, gain, last-entry bit
// (R8) scan list steps in order, wraps after last
// (R9) every external falling edge starts one conversion
// (R10) external source keeps below maximum sampling rate
// (R11) block mode counts conversions, then sets done
// (R12) done stays until next first trigger
// (R13) samples go to consecutive RAM words
// (R14) any write to start address triggers
// (R15) timer mode: first trigger, then timer pulses
// (R16) completion interrupt when count runs out
// (R17) memory interrupt after every 32768 conversions
// (R18) status bit6 shows most recently filled half
// (R19) switching to software trigger halts continuous
// (R20) second trigger turns continuous timed into block
// (R21) stop trigger records last pre-trigger sample index
// (R22) host programs timer control words, then counts
// (R23) prescaler on 2 MHz feeds conversion timer
// (R24) active-low trigger output on every trigger
// (R25) end or reset rewinds scan and RAM pointers
// (R26) continuous RAM address wraps to start
// (R27) host RAM access waits behind sample store
module adcsq_sequencer
	import adcsq_pkg::*;
(
	input wire logic                           clock_i,
	input wire logic                           reset_n_i,
	input wire logic                           reg_wr_i,
	input wire logic                           reg_rd_i,
	input wire logic [adcsq_pkg::SEL_W-1:0]    reg_sel_i,
	input wire logic [15:0]                    reg_wdata_i,
	output logic     [15:0]                    reg_rdata_o,
	input wire logic                           ram_req_i,
	input wire logic                           ram_we_i,
	input wire logic [adcsq_pkg::ADDR_W-1:0]   ram_addr_i,
	input wire logic [adcsq_pkg::SAMPLE_W-1:0] ram_wdata_i,
	output logic     [adcsq_pkg::SAMPLE_W-1:0] ram_rdata_o,
	output logic                               ram_ack_o,
	input wire logic                           ext_trig_i,
	output logic                               trig_out_n_o,
	output logic                               conv_start_o,
	output logic     [adcsq_pkg::SC_CHAN_W-1:0] conv_chan_o,
	output logic     [adcsq_pkg::SC_GAIN_W-1:0] conv_gain_o,
	input wire logic                           conv_done_i,
	input wire logic [adcsq_pkg::ADC_W-1:0]    conv_data_i,
	input wire logic                           irq_ack_i,
	output logic                               irq_o,
	output logic                               led_red_o,
	output logic                               led_green_o,
	output logic                               sysfail_n_o
);
	typedef struct packed {
		logic [7:0]                 status;
		logic [3:0]                 ctl;
		logic                       done;
		logic                       mem_half;
		logic                       irq_pend;
		logic [15:0]                count;
		logic [15:0]                remain;
		logic [15:0]                pre_ptr;
		logic [ADDR_W-1:0]          samp_idx;
		logic [7:0]                 scan_wp;
		logic [7:0]                 scan_rp;
		logic                       running;
		logic                       timing;
		logic                       post;
		logic                       busy;
		logic [2:0]                 ext_s;
		logic                       trig_n;
		logic                       conv_start;
		logic [SC_CHAN_W-1:0]       chan;
		logic [SC_GAIN_W-1:0]       gain;
		logic [15:0]                rdata;
		logic [SAMPLE_W-1:0]        ram_rdata;
		logic                       ram_ack;
		logic                       acq_last;
	} adcsq_seq_state_t;

	adcsq_seq_state_t    q;
	adcsq_seq_state_t    d;
	logic [7:0]          scan_mem [SCAN_WORDS];
	logic [SAMPLE_W-1:0] sample_ram [RAM_WORDS];
	logic [7:0]          code;
	logic                sel_wr_scan;
	logic                ext_fall;
	logic                sw_trig;
	logic                user_trig;
	logic                tmr_fire;
	logic                start_evt;
	logic                stop_evt;
	logic                host_want;
	logic                host_go;
	logic                acq_go;
	logic                block_count;

	adcsq_stream_if #(.WIDTH(FIFO_W)) fill_if ();
	adcsq_stream_if #(.WIDTH(FIFO_W)) drain_if ();

	function automatic logic wr_hit(input logic wr, input logic [SEL_W-1:0] sel,
			input logic [SEL_W-1:0] which);
		return wr && (sel == which);
	endfunction

	adcsq_timer u_timer (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.run_i     (q.ctl[CT_TIMER] & q.timing),
		.ctl_wr_i  (wr_hit(reg_wr_i, reg_sel_i, SEL_CTR_CTL)),
		.psc_wr_i  (wr_hit(reg_wr_i, reg_sel_i, SEL_PRESCALE)),
		.ctm_wr_i  (wr_hit(reg_wr_i, reg_sel_i, SEL_CONV_TMR)),
		.wdata_i   (reg_wdata_i[7:0]),
		.fire_o    (tmr_fire)
	); // (R23) (R22)

	adcsq_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.in_if     (fill_if),
		.out_if    (drain_if)
	);

	assign code        = scan_mem[q.scan_rp];
	assign sel_wr_scan = wr_hit(reg_wr_i, reg_sel_i, SEL_SCAN);
	// only the second and third stages feed logic
	assign ext_fall    = q.ext_s[2] & ~q.ext_s[1]; // (R9)
	assign sw_trig     = wr_hit(reg_wr_i, reg_sel_i, SEL_START); // (R14)
	assign user_trig   = q.ctl[CT_EXTTRIG] ? ext_fall : sw_trig; // (R5) (R19)
	assign block_count = ~q.ctl[CT_CONT] | q.post; // (R3)

	// in timer mode only the first user trigger converts; a later one only stops a continuous run
	always_comb begin
		start_evt = user_trig;
		stop_evt  = 1'b0;
		if (q.ctl[CT_TIMER]) begin // (R6)
			start_evt = q.timing ? tmr_fire : user_trig; // (R15)
			stop_evt  = q.timing & user_trig & q.ctl[CT_CONT] & ~q.post; // (R20)
		end
	end

	// the sample store wins, but never twice in a row while the host waits
	assign host_want      = ram_req_i & ~q.ram_ack;
	assign acq_go         = drain_if.valid & (~host_want | ~q.acq_last); // (R27)
	assign host_go        = host_want & ~acq_go; // (R27)
	assign drain_if.ready = acq_go;

	assign fill_if.valid = conv_done_i & q.busy;
	assign fill_if.data  = {q.samp_idx, conv_data_i, LEFT_PAD'(0)}; // (R1) (R13)

	always_comb begin
		d            = q;
		d.trig_n     = 1'b1;
		d.conv_start = 1'b0;
		d.ram_ack    = host_go;
		d.acq_last   = acq_go;
		d.ext_s      = {q.ext_s[1:0], ext_trig_i};

		if (reg_wr_i) begin
			case (reg_sel_i)
				SEL_STATUS:  d.status = reg_wdata_i[7:0] & STATUS_WMASK; // (R2)
				SEL_CONTROL: d.ctl = reg_wdata_i[3:0];
				SEL_COUNT:   d.count = reg_wdata_i;
				default:     d.status = q.status;
			endcase
		end
		if (sel_wr_scan) begin
			d.scan_wp = reg_wdata_i[SC_LAST] ? 8'h00 : q.scan_wp + 8'h01; // (R7)
		end
		if (reg_rd_i) begin
			case (reg_sel_i)
				SEL_STATUS: begin
					d.rdata              = {8'h00, q.status};
					d.rdata[ST_MEM_HALF] = q.mem_half; // (R18)
					d.rdata[ST_DONE]     = q.done; // (R11)
				end
				SEL_CONTROL:      d.rdata = {12'h000, q.ctl};
				SEL_COUNT:        d.rdata = q.count;
				SEL_PRE_TRIG_PTR: d.rdata = q.pre_ptr;
				default:          d.rdata = 16'h0000;
			endcase
		end
		if (host_go && !ram_we_i) begin
			d.ram_rdata = sample_ram[ram_addr_i];
		end

		if (irq_ack_i) begin
			d.irq_pend = 1'b0;
		end

		if (start_evt || stop_evt) begin
			d.trig_n = 1'b0; // (R24)
		end

		// first trigger of a new acquisition clears the old completion
		if (start_evt && !q.running) begin
			d.done    = 1'b0; // (R12)
			d.running = 1'b1;
			d.timing  = q.ctl[CT_TIMER]; // (R15)
			d.remain  = q.count; // (R11)
		end
		// triggers meeting a busy converter or a full buffer are dropped
		if (start_evt && !q.busy && fill_if.ready) begin
			d.conv_start = 1'b1;
			d.busy       = 1'b1;
			d.chan       = code[SC_CHAN_LSB +: SC_CHAN_W]; // (R7)
			d.gain       = code[SC_GAIN_LSB +: SC_GAIN_W]; // (R7)
		end
		if (stop_evt) begin
			d.post    = 1'b1; // (R20)
			d.remain  = q.count; // (R20)
			d.pre_ptr = q.samp_idx - 16'h0001; // (R21)
		end

		if (fill_if.valid) begin
			d.busy     = 1'b0;
			d.scan_rp  = code[SC_LAST] ? 8'h00 : q.scan_rp + 8'h01; // (R8)
			d.samp_idx = q.samp_idx + 16'h0001; // (R13) (R26)
			if (q.samp_idx[14:0] == HALF_LAST) begin
				d.mem_half = q.samp_idx[15]; // (R18)
				if (q.ctl[CT_CONT] && q.ctl[CT_MEMIRQ] && !q.post) begin // (R4)
					d.irq_pend = 1'b1; // (R17)
				end
			end
			if (block_count) begin
				d.remain = q.remain - 16'h0001; // (R11)
				if (q.remain == 16'h0001) begin
					d.done     = 1'b1; // (R11)
					d.running  = 1'b0;
					d.timing   = 1'b0;
					d.post     = 1'b0;
					d.scan_rp  = 8'h00; // (R25)
					d.samp_idx = '0; // (R25)
					if (!q.ctl[CT_MEMIRQ]) begin // (R4)
						d.irq_pend = 1'b1; // (R16)
					end
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			q        <= '0;
			q.status <= STATUS_RST;
			q.ctl    <= CONTROL_RST;
			q.trig_n <= 1'b1; // (R25)
		end else begin
			q <= d;
		end
	end

	// scan codes survive a reset; only the pointers are rewound
	always_ff @(posedge clock_i) begin
		if (sel_wr_scan) begin
			scan_mem[q.scan_wp] <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (acq_go) begin
			sample_ram[drain_if.data[FIFO_W-1 -: ADDR_W]] <= drain_if.data[SAMPLE_W-1:0]; // (R13)
		end else if (host_go && ram_we_i) begin
			sample_ram[ram_addr_i] <= ram_wdata_i;
		end
	end

	assign reg_rdata_o  = q.rdata;
	assign ram_rdata_o  = q.ram_rdata;
	assign ram_ack_o    = q.ram_ack;
	assign trig_out_n_o = q.trig_n;
	assign conv_start_o = q.conv_start;
	assign conv_chan_o  = q.chan;
	assign conv_gain_o  = q.gain;
	assign irq_o        = q.status[ST_IRQ_EN] & q.irq_pend; // (R2) (R16) (R17)
	assign led_red_o    = ~q.status[ST_RED_OFF]; // (R2)
	assign led_green_o  = q.status[ST_GREEN]; // (R2)
	assign sysfail_n_o  = q.status[ST_RED_OFF]; // (R2)
endmodule
`default_nettype wire

// *** adcsq_chk.sv ***
// adcsq_chk: port-level assertions for the acquisition sequencer.
// assumes it is bound into adcsq_sequencer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk
	import adcsq_pkg::*;
(
	input wire logic                            clock_i,
	input wire logic                            reset_n_i,
	input wire logic                            reg_wr_i,
	input wire logic [adcsq_pkg::SEL_W-1:0]     reg_sel_i,
	input wire logic [15:0]                     reg_wdata_i,
	input wire logic                            ram_req_i,
	input wire logic                            ram_ack_o,
	input wire logic                            trig_out_n_o,
	input wire logic                            conv_start_o,
	input wire logic [adcsq_pkg::SC_CHAN_W-1:0] conv_chan_o,
	input wire logic                            irq_o,
	input wire logic                            led_red_o,
	input wire logic                            led_green_o,
	input wire logic                            sysfail_n_o
);
	// shadow of written mode bits; timer and external modes change what a start write does
	logic [3:0] ctl_q;
	logic       ien_q;
	wire        st_wr = reg_wr_i && reg_sel_i == SEL_STATUS;
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ctl_q <= 4'h0;
			ien_q <= 1'b0;
		end else begin
			if (reg_wr_i && reg_sel_i == SEL_CONTROL)
				ctl_q <= reg_wdata_i[3:0];
			if (st_wr)
				ien_q <= reg_wdata_i[3];
		end
	end
	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	chk_red_follows: assert property (st_wr |=> led_red_o == !$past(reg_wdata_i[0]))
		else $error("red indicator does not follow status write");
	chk_green_follows: assert property (st_wr |=> led_green_o == $past(reg_wdata_i[1]))
		else $error("green indicator does not follow status write");
	chk_fail_line: assert property (sysfail_n_o != led_red_o)
		else $error("failure line disagrees with red indicator");
	chk_soft_trig: assert property (
		reg_wr_i && reg_sel_i == SEL_START && ctl_q[3:2] == 2'b00 |=> !trig_out_n_o)
		else $error("start write gave no trigger pulse");
	chk_start_marked: assert property (conv_start_o |-> !trig_out_n_o)
		else $error("conversion started without trigger pulse");
	chk_ram_wait: assert property ($rose(ram_req_i) |-> ##[1:2] ram_ack_o)
		else $error("host sample access not answered in time");
	chk_ack_pulse: assert property (ram_ack_o |=> !ram_ack_o)
		else $error("host access acknowledge longer than one cycle");
	chk_irq_gated: assert property (!ien_q && !$past(ien_q) |-> !irq_o)
		else $error("interrupt raised while disabled");
	chk_chan_hold: assert property (!conv_start_o |-> $stable(conv_chan_o))
		else $error("channel changed without a conversion start");
endmodule
bind adcsq_sequencer adcsq_chk adcsq_chk_inst (
	.clock_i, .reset_n_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .ram_req_i, .ram_ack_o,
	.trig_out_n_o, .conv_start_o, .conv_chan_o, .irq_o, .led_red_o, .led_green_o,
	.sysfail_n_o
);
`default_nettype wire

// *** adcsq_conv_model.sv ***
// adcsq_conv_model: behavioural converter, one result per start pulse.
// assumes one start at a time; result = {gain, channel, start count} so it is predictable.
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model
	import adcsq_pkg::*;
(
	input wire logic                            clock_i,
	input wire logic                            slow_i,
	input wire logic                            start_i,
	input wire logic [adcsq_pkg::SC_CHAN_W-1:0] chan_i,
	input wire logic [adcsq_pkg::SC_GAIN_W-1:0] gain_i,
	output logic                                done_o,
	output logic [adcsq_pkg::ADC_W-1:0]         data_o
);
	int unsigned      left = 0;
	int unsigned      seq = 0;
	logic [ADC_W-1:0] res = 12'h000;
	initial done_o = 1'b0;
	initial data_o = 12'h000;
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		// data is only valid with done; elsewhere it keeps changing
		data_o <= ~data_o;
		if (start_i) begin
			res = {gain_i, chan_i, seq[4:0]};
			seq++;
			left = slow_i ? 40 : 3;
		end else if (left != 0) begin
			left--;
			if (left == 0) begin
				done_o <= 1'b1;
				data_o <= res;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// tb_top: self-checking bench for the acquisition sequencer with a converter model.
// assumes the checker binds itself; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adcsq_pkg::*;
	logic                 clock_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [SEL_W-1:0]     reg_sel_i = 4'h0;
	logic [15:0]          reg_wdata_i = 16'h0000, reg_rdata_o, ram_wdata_i = 16'h0000;
	logic                 ram_req_i = 1'b0, ram_we_i = 1'b0, ram_ack_o, ext_trig_i = 1'b1;
	logic [ADDR_W-1:0]    ram_addr_i = 16'h0000;
	logic [SAMPLE_W-1:0]  ram_rdata_o;
	logic                 trig_out_n_o, conv_start_o, conv_done_i, irq_o, slow = 1'b0;
	logic                 irq_ack_i = 1'b0, led_red_o, led_green_o, sysfail_n_o;
	logic [SC_CHAN_W-1:0] conv_chan_o;
	logic [SC_GAIN_W-1:0] conv_gain_o;
	logic [ADC_W-1:0]     conv_data_i;
	logic [31:0]          rnd = 32'd69169;
	logic [7:0]           scan[$];
	logic [15:0]          mem[int];
	int err_count = 0, n_compared = 0, n_starts = 0, sidx = 0, ptr = 0, cyc = 0, t_last = 0;
	int per = 0;
	adcsq_sequencer adcsq_sequencer_inst (.clock_i, .reset_n_i, .reg_wr_i, .reg_rd_i,
		.reg_sel_i, .reg_wdata_i, .reg_rdata_o, .ram_req_i, .ram_we_i, .ram_addr_i,
		.ram_wdata_i, .ram_rdata_o, .ram_ack_o, .ext_trig_i, .trig_out_n_o, .conv_start_o,
		.conv_chan_o, .conv_gain_o, .conv_done_i, .conv_data_i, .irq_ack_i, .irq_o,
		.led_red_o, .led_green_o, .sysfail_n_o);
	adcsq_conv_model adcsq_conv_model_inst (.clock_i, .slow_i(slow), .start_i(conv_start_o),
		.chan_i(conv_chan_o), .gain_i(conv_gain_o), .done_o(conv_done_i), .data_o(conv_data_i));
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) cyc++;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stall(input string what);
		err_count++;
		$display("mismatch %s expected progress seen timeout", what);
		report_and_stop();
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// scan-list model: each start must carry the next code and lands at the next RAM word
	always @(negedge clock_i) if (conv_start_o === 1'b1) begin
		check("chan", {11'h0, scan[sidx][4:0]}, {11'h0, conv_chan_o});
		check("gain", {14'h0, scan[sidx][6:5]}, {14'h0, conv_gain_o});
		mem[ptr] = {scan[sidx][6:5], scan[sidx][4:0], n_starts[4:0], 4'h0};
		sidx = scan[sidx][7] ? 0 : sidx + 1;
		ptr = (ptr + 1) % 65536;
		per = cyc - t_last;
		t_last = cyc;
		n_starts++;
	end
	task automatic wr(input logic [3:0] sel, input logic [15:0] d);
		reg_sel_i = sel;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [3:0] sel, output logic [15:0] d);
		reg_sel_i = sel;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
		tick(1);
	endtask
	task automatic ram(input logic we, input logic [15:0] a, d, output logic [15:0] q);
		int n;
		ram_we_i = we;
		ram_addr_i = a;
		ram_wdata_i = d;
		ram_req_i = 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (ram_ack_o !== 1'b1 && n < 4);
		if (ram_ack_o !== 1'b1)
			stall("ram ack");
		q = ram_rdata_o;
		ram_req_i = 1'b0;
		tick(1);
	endtask
	task automatic wait_for(input int target, input int lim);
		int n;
		for (n = 0; n < lim && n_starts < target; n++)
			tick(1);
		if (n_starts < target)
			stall("conversion start");
	endtask
	task automatic wait_done;
		logic [15:0] s;
		int n;
		s = 16'h0000;
		for (n = 0; n < 3000 && s[7] !== 1'b1; n++)
			rd(SEL_STATUS, s);
		if (s[7] !== 1'b1)
			stall("done flag");
		sidx = 0;
		ptr = 0;
	endtask
	task automatic sw_trig;
		int n;
		int t;
		t = n_starts + 1;
		rnd = lfsr(rnd);
		slow = rnd[0];
		wr(SEL_START, {8'h00, rnd[15:8]});
		wait_for(t, 4);
		for (n = 0; n < 100 && conv_done_i !== 1'b1; n++)
			tick(1);
		tick(4);
	endtask
	initial begin
		#400us;
		stall("run");
	end
	initial begin
		logic [15:0] v;
		int k;
		int b;
		tick(5);
		reset_n_i = 1'b1;
		rd(SEL_STATUS, v);
		check("status reset", 16'h0000, v);
		check("red reset", 16'h0001, {15'h0, led_red_o});
		rd(4'hf, v);
		check("unmapped", 16'h0000, v);
		wr(SEL_STATUS, 16'h00ff);
		rd(SEL_STATUS, v);
		check("status mask", 16'h000b, v);
		check("leds", 16'h0002, {14'h0, led_green_o, led_red_o});
		$display("test registers done");
		wr(SEL_CONTROL, 16'h0000);
		for (k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			scan.push_back({k == 2, rnd[6:0]});
			wr(SEL_SCAN, {8'h00, scan[k]});
		end
		wr(SEL_COUNT, 16'h0005);
		repeat (5) sw_trig();
		wait_done();
		check("starts", 16'd5, n_starts[15:0]);
		check("irq", 16'h0001, {15'h0, irq_o});
		irq_ack_i = 1'b1;
		tick(1);
		irq_ack_i = 1'b0;
		tick(1);
		check("irq ack", 16'h0000, {15'h0, irq_o});
		for (k = 0; k < 5; k++) begin
			ram(1'b0, k[15:0], 16'h0000, v);
			check("sample", mem[k], v);
		end
		rd(SEL_STATUS, v);
		check("done held", 16'h0001, {15'h0, v[7]});
		for (k = 0; k < 5; k++) begin
			fork
				sw_trig();
				begin
					tick(5 + k);
					ram(1'b1, 16'h0100 + k[15:0], rnd[15:0], v);
				end
			join
			ram(1'b0, 16'h0100 + k[15:0], 16'h0000, v);
			check("host word", rnd[15:0], v);
			if (k == 0) begin
				rd(SEL_STATUS, v);
				check("done cleared", 16'h0000, {15'h0, v[7]});
			end
		end
		wait_done();
		$display("test block software done");
		irq_ack_i = 1'b1;
		tick(1);
		irq_ack_i = 1'b0;
		wr(SEL_CONTROL, 16'h0006);
		wr(SEL_COUNT, 16'h0002);
		b = n_starts;
		wr(SEL_START, 16'h0000);
		tick(10);
		check("start ignored", b[15:0], n_starts[15:0]);
		for (k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			ext_trig_i = 1'b0;
			wait_for(b + k + 1, 8);
			tick(20);
			ext_trig_i = 1'b1;
			tick(500 + rnd[5:0]);
		end
		check("edges", b[15:0] + 16'd2, n_starts[15:0]);
		wait_done();
		check("no irq", 16'h0000, {15'h0, irq_o});
		$display("test external trigger done");
		slow = 1'b0;
		wr(SEL_CONTROL, 16'h0009);
		wr(SEL_CTR_CTL, 16'h0054);
		wr(SEL_PRESCALE, 16'h0002);
		wr(SEL_CTR_CTL, 16'h0094);
		wr(SEL_CONV_TMR, 16'h0005);
		wr(SEL_COUNT, 16'h0003);
		b = n_starts;
		wr(SEL_START, 16'h00a5);
		wait_for(b + 4, 2500);
		check("period", 16'd500, per[15:0]);
		tick(100);
		wr(SEL_START, 16'h005a);
		wait_for(b + 7, 2000);
		wait_done();
		tick(1000);
		check("post count", b[15:0] + 16'd7, n_starts[15:0]);
		check("irq", 16'h0001, {15'h0, irq_o});
		rd(SEL_PRE_TRIG_PTR, v);
		check("pre pointer", 16'h0003, v);
		for (k = 0; k < 7; k++) begin
			ram(1'b0, k[15:0], 16'h0000, v);
			check("timed sample", mem[k], v);
		end
		$display("test timed stop trigger done");
		report_and_stop();
	end
endmodule
`default_nettype wire
